// File: eeprom_host_consts.vh
`ifndef EEPROM_HOST_CONSTS_VH
`define EEPROM_HOST_CONSTS_VH
// ----------------------------------------------------------------
// Register map of the controller
// ----------------------------------------------------------------
`define REG_CONTROL     8'h00
`define REG_ADDRESS     8'h04
`define REG_STATUS      8'h08
`define REG_DIVIDER     8'h0C
`define BUF_SELECT      2'h1
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define CTL_GO          0
`define CTL_OP_LSB      1
`define CTL_OP_MSB      3
`define CTL_LAST_LSB    4
`define CTL_LAST_MSB    7
`define CTL_IDPAGE      8
`define CTL_WP          9
`define CTL_CS          10
`define ST_BUSY         0
`define ST_SEL_NACK     1
`define ST_ADDR_NACK    2
`define ST_DATA_NACK    3
`define ST_DONE         4
// ----------------------------------------------------------------
// Commands and serial codes
// ----------------------------------------------------------------
`define OP_WRITE        3'h0
`define OP_RD_RAND      3'h1
`define OP_RD_CUR       3'h2
`define OP_POLL         3'h3
`define OP_LOCK_STATUS  3'h4
`define OP_LOCK         3'h5
`define TYPE_ARRAY      4'hA
`define TYPE_ID         4'hB
`define DIR_WRITE       1'h0
`define DIR_READ        1'h1
`define LOCK_DATA       8'hFF
`define ID_LOCK_BIT     7
`define PAGE_LAST       4'hF
`define LAST_BIT        4'h8
`define LAST_QUARTER    2'h3
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CORE_PERIOD_NS  20
`define SCL_PERIOD_NS   10000
`define QUARTER_CYCLES  ((`SCL_PERIOD_NS) / ((`CORE_PERIOD_NS) * 4))
`endif

// File: sync2.v
`default_nettype none
// ----------------------------------------------------------------
// Two-stage synchroniser for inputs from outside the clock domain
// ----------------------------------------------------------------
module sync2 #(
   parameter WIDTH = 1
) (
   input  wire             clk,     // Core clock.
   input  wire             rst,     // Synchronous reset, active high.
   input  wire [WIDTH-1:0] din,     // Asynchronous input.
   output reg  [WIDTH-1:0] dout     // Synchronised output.
);
   reg [WIDTH-1:0] meta;

   // The first stage is read only by the second stage.
   always @(posedge clk) begin
      if (rst) begin
         meta <= {WIDTH{1'b1}};
         dout <= {WIDTH{1'b1}};
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // sync2
`default_nettype wire

// File: tick_divider.v
`default_nettype none
// ----------------------------------------------------------------
// Enable pulse divider for the quarter-bit rate
// ----------------------------------------------------------------
module tick_divider (
   input  wire        clk,      // Core clock.
   input  wire        rst,      // Synchronous reset, active high.
   input  wire        run,      // Count only while a transfer runs.
   input  wire [15:0] period,   // Cycles per tick, zero treated as one.
   output reg         tick      // One-cycle enable pulse.
);
   reg [15:0] count;

   // Restarting from zero when idle keeps the first quarter full length.
   always @(posedge clk) begin
      if (rst || !run) begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end else if (count + 16'h0001 >= period) begin
         count <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule // tick_divider
`default_nettype wire

// File: eeprom_host.v
// Notes on behaviour
// - Write: select with write direction, address, data.
// - Page write bytes stay within one page.
// - Identification write uses type 1011b, A7 zero.
// - Lock: type 1011b, A7 one, data bit1 set.
// - Poll with select until device acknowledges.
// - Random read: address, repeated Start, read select.
// - Counter shared; prefer random reads for array.
// - Acknowledge each byte, no acknowledge last, Stop.
// - Identification read: random read, stay in page.
// - Lock status: header plus one data byte.
// - Follow lock status query by Start then Stop.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`default_nettype none
`include "eeprom_host_consts.vh"
module eeprom_host (
   input  wire        CORE_CLK,          // Core clock, 50 MHz.
   input  wire        SYS_RST,           // Synchronous reset, active high.
   input  wire [7:0]  AWADDR,            // Write address.
   input  wire        AWVALID,           // Write address valid.
   output reg         AWREADY,           // Write address ready.
   input  wire [31:0] WDATA,             // Write data.
   input  wire [3:0]  WSTRB,             // Write byte strobes.
   input  wire        WVALID,            // Write data valid.
   output reg         WREADY,            // Write data ready.
   output reg  [1:0]  BRESP,             // Write response.
   output reg         BVALID,            // Write response valid.
   input  wire        BREADY,            // Write response ready.
   input  wire [7:0]  ARADDR,            // Read address.
   input  wire        ARVALID,           // Read address valid.
   output reg         ARREADY,           // Read address ready.
   output reg  [31:0] RDATA,             // Read data.
   output reg  [1:0]  RRESP,             // Read response.
   output reg         RVALID,            // Read data valid.
   input  wire        RREADY,            // Read data ready.
   output reg         SCL_OUT,           // Clock pin output level, always low.
   output reg         SCL_OE,            // Clock pin pulled low when high.
   input  wire        SDA_IN,            // Data pin level.
   output reg         SDA_OUT,           // Data pin output level, always low.
   output reg         SDA_OE,            // Data pin pulled low when high.
   output reg         WRITE_PROTECT_IN,  // Drives the device write-protect input.
   output reg         CHIP_SELECT_PIN    // Drives the device chip select strap.
);
   // ----------------------------------------------------------------
   // Sequencer states and bit engine states
   // ----------------------------------------------------------------
   localparam S_IDLE    = 4'h0;
   localparam S_START   = 4'h1;
   localparam S_SEL_W   = 4'h2;
   localparam S_ADDR    = 4'h3;
   localparam S_WDATA   = 4'h4;
   localparam S_RESTART = 4'h5;
   localparam S_SEL_R   = 4'h6;
   localparam S_RDATA   = 4'h7;
   localparam S_ABORT   = 4'h8;
   localparam S_STOP    = 4'h9;
   localparam B_IDLE    = 2'h0;
   localparam B_START   = 2'h1;
   localparam B_BITS    = 2'h2;
   localparam B_STOP    = 2'h3;

   reg  [3:0]  state;
   reg  [1:0]  bstate;
   reg  [1:0]  quarter;
   reg  [3:0]  bit_cnt;
   reg  [7:0]  tx_shift;
   reg  [7:0]  rx_shift;
   reg         rx_mode;
   reg         send_ack;
   reg         ack_in;
   reg         launched;
   reg         bit_done;
   reg  [7:0]  buffer [0:15];
   reg  [2:0]  op;
   reg  [3:0]  last;
   reg  [3:0]  idx;
   reg         id_page;
   reg  [9:0]  address;
   reg  [15:0] divider;
   reg         sel_nack;
   reg         addr_nack;
   reg         data_nack;
   reg         done;
   wire        busy;
   wire        sda_sync;
   wire        tick;
   wire        wr_fire;
   wire        rd_fire;
   wire [31:0] control_word;
   reg  [3:0]  next_last;
   reg  [7:0]  launch_byte;
   wire [31:0] address_word;
   wire [31:0] divider_word;
   wire [31:0] divider_reset;

   assign busy    = (state != S_IDLE);
   assign wr_fire = AWVALID && AWREADY && WVALID && WREADY;
   assign rd_fire = ARVALID && ARREADY;

   // Merges a write into an older word lane by lane.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer      i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
         end
      end
   endfunction

   // Builds a select code from the page choice and direction.
   function [7:0] select_code;
      input       idp;
      input       cs;
      input [1:0] hi;
      input       dir;
      begin
         select_code = {(idp ? `TYPE_ID : `TYPE_ARRAY), cs, hi, dir};
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchroniser and quarter-bit divider
   // ----------------------------------------------------------------
   sync2 #(.WIDTH(1)) u_sda_sync (
      .clk  (CORE_CLK),
      .rst  (SYS_RST),
      .din  (SDA_IN),
      .dout (sda_sync)
   );

   tick_divider u_div (
      .clk    (CORE_CLK),
      .rst    (SYS_RST),
      .run    (bstate != B_IDLE),
      .period (divider),
      .tick   (tick)
   );

   // ----------------------------------------------------------------
   // Register bus slave
   // ----------------------------------------------------------------
   assign control_word = merge(32'h0000_0000, WDATA, WSTRB);

   // Merged words are cut to the register widths where they are stored.
   assign address_word  = merge({22'h000000, address}, WDATA, WSTRB);
   assign divider_word  = merge({16'h0000, divider}, WDATA, WSTRB);
   assign divider_reset = `QUARTER_CYCLES;

   // Page writes and identification reads are clipped at the page end.
   always @* begin
      next_last = control_word[`CTL_LAST_MSB:`CTL_LAST_LSB];
      if (control_word[`CTL_OP_MSB:`CTL_OP_LSB] == `OP_LOCK ||
          control_word[`CTL_OP_MSB:`CTL_OP_LSB] == `OP_LOCK_STATUS) begin
         next_last = 4'h0;
      end else if ((control_word[`CTL_OP_MSB:`CTL_OP_LSB] == `OP_WRITE ||
                    control_word[`CTL_IDPAGE]) &&
                   next_last > (`PAGE_LAST - address[3:0])) begin
         next_last = `PAGE_LAST - address[3:0];
      end
   end

   // Write handshakes are offered one cycle after both valids, reads one cycle after ARVALID, one at a time.
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         AWREADY <= 1'b0;
         WREADY  <= 1'b0;
         BVALID  <= 1'b0;
         BRESP   <= `RESP_OKAY;
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RRESP   <= `RESP_OKAY;
         RDATA   <= 32'h0000_0000;
      end else begin
         AWREADY <= AWVALID && WVALID && !AWREADY && !BVALID;
         WREADY  <= AWVALID && WVALID && !AWREADY && !BVALID;
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= (AWADDR[7:6] == `BUF_SELECT || AWADDR == `REG_CONTROL ||
                       AWADDR == `REG_ADDRESS || AWADDR == `REG_STATUS ||
                       AWADDR == `REG_DIVIDER) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
         ARREADY <= ARVALID && !ARREADY && !RVALID;
         if (rd_fire) begin
            RVALID <= 1'b1;
            RRESP  <= `RESP_OKAY;
            if (ARADDR[7:6] == `BUF_SELECT) begin
               RDATA <= {24'h000000, buffer[ARADDR[5:2]]};
            end else if (ARADDR == `REG_CONTROL) begin
               RDATA <= {21'h000000, CHIP_SELECT_PIN, WRITE_PROTECT_IN, id_page,
                         last, op, 1'b0};
            end else if (ARADDR == `REG_ADDRESS) begin
               RDATA <= {22'h000000, address};
            end else if (ARADDR == `REG_STATUS) begin
               RDATA <= {27'h0000000, done, data_nack, addr_nack, sel_nack, busy};
            end else if (ARADDR == `REG_DIVIDER) begin
               RDATA <= {16'h0000, divider};
            end else begin
               RDATA <= 32'h0000_0000;
               RRESP <= `RESP_SLVERR;
            end
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // Settings are frozen while a transfer runs; writes then are dropped.
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         op               <= `OP_WRITE;
         last             <= 4'h0;
         id_page          <= 1'b0;
         address          <= 10'h000;
         divider          <= divider_reset[15:0];
         WRITE_PROTECT_IN <= 1'b0;
         CHIP_SELECT_PIN  <= 1'b0;
      end else if (wr_fire && !busy) begin
         if (AWADDR == `REG_CONTROL) begin
            op               <= control_word[`CTL_OP_MSB:`CTL_OP_LSB];
            last             <= next_last;
            id_page          <= control_word[`CTL_IDPAGE];
            WRITE_PROTECT_IN <= control_word[`CTL_WP];
            CHIP_SELECT_PIN  <= control_word[`CTL_CS];
         end else if (AWADDR == `REG_ADDRESS) begin
            address <= address_word[9:0];
         end else if (AWADDR == `REG_DIVIDER) begin
            divider <= divider_word[15:0];
         end
      end
   end

   // Software fills the buffer when idle, the reader fills it when busy.
   always @(posedge CORE_CLK) begin
      if (wr_fire && !busy && AWADDR[7:6] == `BUF_SELECT && WSTRB[0]) begin
         buffer[AWADDR[5:2]] <= WDATA[7:0];
      end else if (state == S_RDATA && bit_done) begin
         buffer[idx] <= rx_shift;
      end
   end

   // ----------------------------------------------------------------
   // Bit engine: four quarters per bit, pins driven only low
   // ----------------------------------------------------------------
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         bstate   <= B_IDLE;
         quarter  <= 2'h0;
         bit_cnt  <= 4'h0;
         rx_shift <= 8'h00;
         ack_in   <= 1'b1;
         bit_done <= 1'b0;
         SCL_OE   <= 1'b0;
         SDA_OE   <= 1'b0;
         SCL_OUT  <= 1'b0;
         SDA_OUT  <= 1'b0;
      end else begin
         bit_done <= 1'b0;
         if (state != S_IDLE && !launched && bstate == B_IDLE) begin
            quarter <= 2'h0;
            bit_cnt <= 4'h0;
            if (state == S_START || state == S_RESTART || state == S_ABORT) begin
               bstate <= B_START;
            end else if (state == S_STOP) begin
               bstate <= B_STOP;
            end else begin
               bstate <= B_BITS;
            end
         end else if (tick) begin
            quarter <= quarter + 2'h1;
            case (bstate)
               B_START: begin
                  if (quarter == 2'h0) SDA_OE <= 1'b0;
                  if (quarter == 2'h1) SCL_OE <= 1'b0;
                  if (quarter == 2'h2) SDA_OE <= 1'b1;
                  if (quarter == `LAST_QUARTER) begin
                     SCL_OE   <= 1'b1;
                     bstate   <= B_IDLE;
                     bit_done <= 1'b1;
                  end
               end
               B_BITS: begin
                  if (quarter == 2'h0) begin
                     if (bit_cnt == `LAST_BIT) begin
                        SDA_OE <= rx_mode && send_ack;
                     end else begin
                        SDA_OE <= !rx_mode && !tx_shift[7 - bit_cnt[2:0]];
                     end
                  end
                  if (quarter == 2'h1) SCL_OE <= 1'b0;
                  if (quarter == 2'h2) begin
                     if (bit_cnt == `LAST_BIT) begin
                        ack_in <= sda_sync;
                     end else begin
                        rx_shift <= {rx_shift[6:0], sda_sync};
                     end
                  end
                  if (quarter == `LAST_QUARTER) begin
                     SCL_OE <= 1'b1;
                     if (bit_cnt == `LAST_BIT) begin
                        bstate   <= B_IDLE;
                        bit_done <= 1'b1;
                     end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               B_STOP: begin
                  if (quarter == 2'h0) begin
                     SCL_OE <= 1'b1;
                     SDA_OE <= 1'b1;
                  end
                  if (quarter == 2'h1) SCL_OE <= 1'b0;
                  if (quarter == 2'h2) SDA_OE <= 1'b0;
                  if (quarter == `LAST_QUARTER) begin
                     bstate   <= B_IDLE;
                     bit_done <= 1'b1;
                  end
               end
               default: bstate <= B_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Byte sequencer
   // ----------------------------------------------------------------
   // Chooses the byte that each transmit state launches.
   always @* begin
      case (state)
         S_SEL_W: launch_byte = select_code(id_page, CHIP_SELECT_PIN, address[9:8],
                                            `DIR_WRITE);
         S_SEL_R: launch_byte = select_code(id_page, CHIP_SELECT_PIN, address[9:8],
                                            `DIR_READ);
         S_ADDR: begin
            launch_byte = address[7:0];
            if (op == `OP_LOCK) begin
               launch_byte[`ID_LOCK_BIT] = 1'b1;
            end else if (id_page) begin
               launch_byte[`ID_LOCK_BIT] = 1'b0;
            end
         end
         S_WDATA: launch_byte = (op == `OP_LOCK) ? `LOCK_DATA : buffer[idx];
         default: launch_byte = 8'h00;
      endcase
   end

   // A not-acknowledged select or address ends the transfer with Stop.
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state     <= S_IDLE;
         launched  <= 1'b0;
         idx       <= 4'h0;
         tx_shift  <= 8'h00;
         rx_mode   <= 1'b0;
         send_ack  <= 1'b0;
         sel_nack  <= 1'b0;
         addr_nack <= 1'b0;
         data_nack <= 1'b0;
         done      <= 1'b0;
      end else if (state == S_IDLE) begin
         launched <= 1'b0;
         if (wr_fire && AWADDR == `REG_CONTROL && control_word[`CTL_GO]) begin
            state     <= S_START;
            idx       <= 4'h0;
            sel_nack  <= 1'b0;
            addr_nack <= 1'b0;
            data_nack <= 1'b0;
            done      <= 1'b0;
         end
      end else if (!launched && bstate == B_IDLE) begin
         launched <= 1'b1;
         tx_shift <= launch_byte;
         rx_mode  <= (state == S_RDATA);
         send_ack <= (idx != last);
      end else if (bit_done) begin
         launched <= 1'b0;
         case (state)
            S_START: state <= (op == `OP_RD_CUR) ? S_SEL_R : S_SEL_W;
            S_SEL_W: begin
               if (ack_in) begin
                  sel_nack <= 1'b1;
                  state    <= S_STOP;
               end else begin
                  state <= (op == `OP_POLL) ? S_STOP : S_ADDR;
               end
            end
            S_ADDR: begin
               if (ack_in) begin
                  addr_nack <= 1'b1;
                  state     <= S_STOP;
               end else begin
                  state <= (op == `OP_RD_RAND) ? S_RESTART : S_WDATA;
               end
            end
            S_WDATA: begin
               if (ack_in) data_nack <= 1'b1;
               if (op == `OP_LOCK_STATUS) begin
                  state <= S_ABORT;
               end else if (idx == last) begin
                  state <= S_STOP;
               end else begin
                  idx <= idx + 4'h1;
               end
            end
            S_RESTART: state <= S_SEL_R;
            S_SEL_R: begin
               if (ack_in) begin
                  sel_nack <= 1'b1;
                  state    <= S_STOP;
               end else begin
                  state <= S_RDATA;
               end
            end
            S_RDATA: begin
               if (idx == last) begin
                  state <= S_STOP;
               end else begin
                  idx <= idx + 4'h1;
               end
            end
            S_ABORT: state <= S_STOP;
            S_STOP: begin
               state <= S_IDLE;
               done  <= 1'b1;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule // eeprom_host
`default_nettype wire

// File: eeprom_host_assertions.sv
`default_nettype none
// ----------------------------------------
// Register bus and link checks
// ----------------------------------------
module eeprom_host_checker (
   input wire logic CORE_CLK, SYS_RST, AWVALID, WVALID, BREADY, ARVALID, RREADY,
   input wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SCL_OE, SDA_OE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // A write is offered whole, then both halves are taken together.
   sequence s_offer; AWVALID && WVALID && !BVALID && !AWREADY; endsequence
   sequence s_taken; AWREADY && WREADY; endsequence
   a_write_taken: assert property (s_offer |=> s_taken) else $error("write not taken");
   a_resp_follows: assert property (s_taken |=> BVALID) else $error("no response");
   a_ready_pulse: assert property (AWREADY |=> !AWREADY) else $error("ready held");
   a_resp_holds: assert property (BVALID && !BREADY |=> BVALID) else $error("response lost");
   a_resp_ends: assert property (BVALID && BREADY |=> !BVALID) else $error("response stuck");
   a_read_taken: assert property (ARVALID && !RVALID && !ARREADY |=> ARREADY)
      else $error("no read");
   a_read_answer: assert property (ARREADY |=> RVALID) else $error("no read data");
   a_read_holds: assert property (RVALID && !RREADY |=> RVALID) else $error("read data lost");
   // A Start holds the data line low until the clock line is pulled low.
   a_start_frame: assert property ($rose(SDA_OE) && !SCL_OE |=>
      SDA_OE throughout (1'b1 ##[0:300] SCL_OE)) else $error("start not framed");
endmodule // eeprom_host_checker
bind eeprom_host eeprom_host_checker chk (.*);
`default_nettype wire

// File: eeprom_model.sv
`default_nettype none
module eeprom_model #(
   parameter int write_cycle_time = 20000, // Busy span in ns.
   parameter logic [23:0] ident = 24'h5C3D71 // Arbitrary identification bytes.
) (
   input wire logic scl, // Clock line level.
   input wire logic sda, // Data line level.
   input wire logic cs,  // Chip select strap.
   input wire logic wp,  // Write-protect input.
   output logic     pull // Pulls the data line low.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem[1024], idp[16], sh, rb;
   logic [9:0] ctr = 0;
   logic [19:0] q[$];
   int n, st;
   bit ida, lkc, lk, busy, wr, ok;
   initial begin
      pull = 0;
      foreach (mem[i]) mem[i] = 8'hFF;
      foreach (idp[i]) idp[i] = i < 3 ? ident[23 - 8 * i -: 8] : 8'hFF;
   end
   // A Start aborts a truncated command; nothing is seen while busy.
   always @(negedge sda) if (scl === 1 && !busy) begin
      st = 1; n = 0; wr = 0; q.delete();
   end
   // Only a Stop in the tenth slot commits; the busy span then mutes the device.
   always @(posedge sda) if (scl === 1 && !busy) begin
      st = 0; pull = 0;
      if (wr) begin
         foreach (q[i]) begin
            if (q[i][19]) lk |= q[i][1];
            else if (q[i][18]) idp[q[i][11:8]] = q[i][7:0];
            else mem[q[i][17:8]] = q[i][7:0];
            ctr = q[i][17:8] + 10'h001;
         end
         wr = 0; busy = 1; #(write_cycle_time) busy = 0;
      end
   end
   // Bits are taken on the rising clock; the ninth carries the acknowledge.
   always @(posedge scl) if (st != 0) begin
      if (n < 8) begin sh = {sh[6:0], sda}; n++; end
      else begin
         n = 0;
         if (st == 5) st = 4;
         else if (st == 4) begin ctr++; if (sda) st = 0; end
      end
   end
   // The line only changes on the falling clock.
   always @(negedge scl) if (st != 0) begin
      rb = ida ? idp[ctr[3:0]] : mem[ctr];
      pull = st == 4 && n < 8 && !rb[7 - n];
      if (n == 1) wr = 0;
      if (n == 8) case (st)
         1: if (sh[7:5] == 3'h5 && sh[3] == cs) begin
               ida = sh[4]; pull = 1; st = sh[0] ? 5 : 2;
               if (!sh[4] && !sh[0]) ctr[9:8] = sh[2:1];
            end else st = 0;
         2: begin
               lkc = sh[7]; pull = 1; st = 3;
               ctr = ida ? {6'h00, sh[3:0]} : {ctr[9:8], sh};
            end
         3: begin
               ok = !wp && !(ida && lk); pull = ok; wr = ok;
               if (ok) q.push_back({ida && lkc, ida, ctr, sh});
               ctr[3:0]++;
            end
      endcase
   end
endmodule // eeprom_model
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CORE_CLK = 0, SYS_RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
   logic [31:0] WDATA = 32'h0, RDATA, d, s;
   logic [3:0] WSTRB = 4'hF;
   logic [1:0] BRESP, RRESP, r;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, pull;
   logic WRITE_PROTECT_IN, CHIP_SELECT_PIN;
   int errors = 0, compares = 0;
   wire SDA_IN = !(SDA_OE || pull);
   eeprom_host uut (.*);
   eeprom_model far (.scl(!SCL_OE), .sda(SDA_IN), .cs(CHIP_SELECT_PIN),
      .wp(WRITE_PROTECT_IN), .pull(pull));
   initial forever #10 CORE_CLK = ~CORE_CLK;
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CORE_CLK);
      AWADDR <= a; WDATA <= v; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
      fork
         begin do @(posedge CORE_CLK); while (!AWREADY); AWVALID <= 0; end
         begin do @(posedge CORE_CLK); while (!WREADY); WVALID <= 0; end
      join
      while (!BVALID) @(posedge CORE_CLK);
      r = BRESP;
      BREADY <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge CORE_CLK);
      ARADDR <= a; ARVALID <= 1; RREADY <= 1;
      do @(posedge CORE_CLK); while (!ARREADY);
      ARVALID <= 0;
      while (!RVALID) @(posedge CORE_CLK);
      d = RDATA; r = RRESP; RREADY <= 0;
   endtask
   task chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // Issue one command and wait for idle; busy polling has no bound but the watchdog.
   task op(input logic [9:0] a, input logic [10:0] c);
      wr(8'h04, {22'h0, a});
      wr(8'h00, {21'h0, c} | 32'h1);
      do rd(8'h08); while (d[0]);
      s = d & 32'h1F;
   endtask
   task settle;
      do op(10'h000, 11'h006); while (s[1]);
   endtask
   task end_of_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #1500000;
      errors++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge CORE_CLK);
      SYS_RST <= 0;
      rd(8'h0C); chk("divider", 32'h7D, d);
      rd(8'h10); chk("unmapped", 32'h2, {30'h0, r});
      wr(8'h10, 32'h0); chk("write resp", 32'h2, {30'h0, r});
      wr(8'h04, 32'hFFFF_FFFE); rd(8'h04); chk("address", 32'h3FE, d);
      wr(8'h00, 32'hF0); rd(8'h00); chk("clipped count", 32'h10, d);
      wr(8'h0C, 32'h2);
      $display("test registers done");
      wr(8'h40, 32'h5A);
      op(10'h000, 11'h000); chk("byte write", 32'h10, s);
      op(10'h000, 11'h006); chk("busy probe", 32'h12, s);
      settle;
      wr(8'h40, 32'hC1);
      wr(8'h44, 32'hC2);
      op(10'h3FE, 11'h010); chk("page write", 32'h10, s);
      settle;
      op(10'h000, 11'h004); rd(8'h40); chk("current read", 32'h5A, d);
      op(10'h3FF, 11'h012); rd(8'h40); chk("random read", 32'hC2, d);
      rd(8'h44); chk("wrapped read", 32'h5A, d);
      wr(8'h40, 32'h00);
      op(10'h000, 11'h200); chk("protected write", 32'h18, s);
      op(10'h000, 11'h202); rd(8'h40); chk("protected read", 32'h5A, d);
      $display("test array done");
      wr(8'h40, 32'h77);
      op(10'h3F3, 11'h100); chk("id write", 32'h10, s);
      settle;
      op(10'h003, 11'h102); rd(8'h40); chk("id read", 32'h77, d);
      op(10'h000, 11'h108); chk("lock open", 32'h10, s);
      op(10'h000, 11'h10A); chk("lock", 32'h10, s);
      settle;
      op(10'h000, 11'h108); chk("lock shut", 32'h18, s);
      wr(8'h40, 32'h88);
      op(10'h003, 11'h100); chk("locked write", 32'h18, s);
      op(10'h003, 11'h102); rd(8'h40); chk("id kept", 32'h77, d);
      op(10'h000, 11'h406); chk("chip select", 32'h10, s);
      chk("pin levels", 32'h0, {30'h0, SCL_OUT, SDA_OUT});
      $display("test id page done");
      end_of_test;
   end
endmodule // tb
`default_nettype wire
